// File: rtl/stsc_addr_map.sv
// maps the command-block bytes to a target for the positioner
`timescale 1ns/1ns
`default_nettype none
module stsc_addr_map (
    // command block bytes in
    input wire logic lba_mode,
    input wire logic [7:0] low_byte,
    input wire logic [7:0] mid_byte,
    input wire logic [7:0] high_byte,
    input wire logic [3:0] head_field,
    // target out
    output stsc_pkg::stsc_target_s target
);
    // both modes pack the same bytes; lba_mode tells the positioner how
    // to read them (cylinder = high:mid, head = head_field)
    // one driver for the whole struct: {lba_mode, head, high, mid, low}
    assign target = {lba_mode, head_field, high_byte, mid_byte,
        low_byte};
endmodule // stsc_addr_map
`default_nettype wire

// File: rtl/stsc_cfg.svh
// constants for the positioning and temperature sense command block
// ============================================================
// Summary of operation
// - opcodes 70h..7Fh all decode as the positioning command
// - positioning starts a move to the target track and selects the head
// - positioning works without any formatted medium present
// - in block-address mode, address bits 0-7 come from the low byte
// - in block-address mode, bits 8-15 come from mid and 16-23 from high
// - in block-address mode, bits 24-27 come from the head field
// - in track/head mode, mid and high bytes form the cylinder number
// - in track/head mode, the four-bit head field is the head number
// - after a block-address move the current address is returned
// - a command reports the internal temperature to the host
// - opcode F0h decodes as the temperature sense command
// - any other feature value aborts the sense command with an error
// - the sense command runs even in power-up-in-standby
// - a good sense command leaves its temperature code in the count byte
// - code 00h means minus twenty degrees or colder
// - codes 01h-FEh mean code/2 minus twenty degrees
// - code FFh means hotter than 107 degrees
`ifndef STSC_CFG_SVH
`define STSC_CFG_SVH
// ============================================================
// register byte addresses
`define STSC_OFF_FEATURE 12'h000
`define STSC_OFF_COUNT 12'h004
`define STSC_OFF_ADDR_LOW 12'h008
`define STSC_OFF_ADDR_MID 12'h00C
`define STSC_OFF_ADDR_HIGH 12'h010
`define STSC_OFF_UNIT 12'h014
`define STSC_OFF_OPCODE 12'h018
`define STSC_OFF_FAILURE 12'h01C
`define STSC_OFF_STATE 12'h020
`define STSC_OFF_CONTROL 12'h024
// ============================================================
// opcodes and feature value
`define STSC_OP_SEEK_HI 4'h7
`define STSC_OP_SENSE 8'hF0
`define STSC_FEAT_SENSE 8'h01
// ============================================================
// unit register fields
`define STSC_UNIT_LBA_BIT 6
// failure_cause bits
`define STSC_ERR_NOTFOUND_BIT 4
`define STSC_ERR_ABORT_BIT 2
// device_state bits
`define STSC_ST_BUSY_BIT 7
`define STSC_ST_RDY_BIT 6
`define STSC_ST_FAULT_BIT 5
`define STSC_ST_SEEKDONE_BIT 4
`define STSC_ST_ERR_BIT 0
// reset values
`define STSC_STATE_RESET 8'h50
// ============================================================
// temperature code limits and timing
`define STSC_TEMP_MIN_CODE 8'h00
`define STSC_TEMP_MAX_CODE 8'hFF
`define STSC_SEEK_TIMEOUT_US 100
`define STSC_CLK_MHZ 50
`define STSC_SEEK_TIMEOUT_CYC (`STSC_SEEK_TIMEOUT_US * `STSC_CLK_MHZ)
`endif

// File: rtl/stsc_cmd.sv
// command interpreter for the positioning and temperature sense commands
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "stsc_cfg.svh"
module stsc_cmd #(
    parameter int SEEK_TIMEOUT = `STSC_SEEK_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // positioner
    output logic pos_start,
    output stsc_pkg::stsc_target_s pos_target,
    input wire stsc_pkg::stsc_pos_result_s pos_result,
    // temperature sensor (same clock domain)
    output logic temp_request,
    input wire logic temp_valid,
    input wire logic signed [11:0] temp_half_deg,
    // status
    output logic standby_hold
);
    // ============================================================
    // registers
    logic [7:0] feature_reg;
    logic [7:0] count_reg;
    logic [7:0] low_reg;
    logic [7:0] mid_reg;
    logic [7:0] high_reg;
    logic [7:0] unit_reg;
    logic [7:0] opcode_reg;
    logic [7:0] failure_reg;
    logic [7:0] state_reg;
    logic standby_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic pos_start_reg;
    logic temp_req_reg;
    stsc_pkg::stsc_target_s target_reg;
    stsc_pkg::stsc_state_e fsm_reg;
    logic [31:0] timer_reg;

    // ============================================================
    // bus decode
    wire logic setup_ph;
    wire logic acc_ph;
    wire logic wr_en;
    wire logic busy;
    wire logic hit;
    wire logic [7:0] wbyte;
    assign setup_ph = psel && !penable;
    // writes land at the edge that completes the access phase
    assign acc_ph = psel && penable && pready_reg;
    assign busy = state_reg[`STSC_ST_BUSY_BIT];
    assign wr_en = acc_ph && pwrite && !busy;
    assign wbyte = pwdata[7:0];
    assign hit = (paddr == `STSC_OFF_FEATURE) || (paddr == `STSC_OFF_COUNT)
        || (paddr == `STSC_OFF_ADDR_LOW) || (paddr == `STSC_OFF_ADDR_MID)
        || (paddr == `STSC_OFF_ADDR_HIGH) || (paddr == `STSC_OFF_UNIT)
        || (paddr == `STSC_OFF_OPCODE) || (paddr == `STSC_OFF_FAILURE)
        || (paddr == `STSC_OFF_STATE) || (paddr == `STSC_OFF_CONTROL);

    // opcode decode on the written byte
    wire logic op_wr;
    wire logic is_seek;
    wire logic is_sense;
    assign op_wr = wr_en && (paddr == `STSC_OFF_OPCODE);
    assign is_seek = wbyte[7:4] == `STSC_OP_SEEK_HI;
    assign is_sense = wbyte == `STSC_OP_SENSE;
    wire logic feat_ok;
    assign feat_ok = feature_reg == `STSC_FEAT_SENSE;

    // read mux
    wire logic [7:0] rbyte;
    assign rbyte = (paddr == `STSC_OFF_COUNT) ? count_reg :
        (paddr == `STSC_OFF_ADDR_LOW) ? low_reg :
        (paddr == `STSC_OFF_ADDR_MID) ? mid_reg :
        (paddr == `STSC_OFF_ADDR_HIGH) ? high_reg :
        (paddr == `STSC_OFF_UNIT) ? unit_reg :
        (paddr == `STSC_OFF_FAILURE) ? failure_reg :
        (paddr == `STSC_OFF_STATE) ? state_reg :
        (paddr == `STSC_OFF_CONTROL) ? {7'h00, standby_reg} : 8'h00;

    // ============================================================
    // helpers
    stsc_pkg::stsc_target_s map_target;
    wire logic code_valid;
    wire logic [7:0] code;
    stsc_addr_map u_map (
        .lba_mode(unit_reg[`STSC_UNIT_LBA_BIT]),
        .low_byte(low_reg),
        .mid_byte(mid_reg),
        .high_byte(high_reg),
        .head_field(unit_reg[3:0]),
        .target(map_target)
    );
    stsc_temp_enc u_enc (
        .clk(clk),
        .reset(reset),
        .sample_valid(temp_valid && fsm_reg == stsc_pkg::STSC_SENSE_WAIT),
        .sample_half_deg(temp_half_deg),
        .code_valid(code_valid),
        .code(code)
    );

    // ============================================================
    // apb answer: one wait-free access phase, registered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup_ph;
            pslverr_reg <= setup_ph && !hit;
            prdata_reg <= (setup_ph && !pwrite) ? {24'h000000, rbyte} : 32'h0;
        end
    end

    // ============================================================
    // command sequencer
    wire logic seek_fin;
    wire logic timeout;
    assign seek_fin = fsm_reg == stsc_pkg::STSC_SEEK_WAIT && pos_result.done;
    assign timeout = fsm_reg == stsc_pkg::STSC_SEEK_WAIT
        && timer_reg == 32'(SEEK_TIMEOUT - 1);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fsm_reg <= stsc_pkg::STSC_IDLE;
            timer_reg <= 32'h0;
            pos_start_reg <= 1'b0;
            temp_req_reg <= 1'b0;
            target_reg <= '0;
        end else begin
            pos_start_reg <= 1'b0;
            timer_reg <= (fsm_reg == stsc_pkg::STSC_SEEK_WAIT)
                ? timer_reg + 32'h1 : 32'h0;
            unique case (fsm_reg)
                stsc_pkg::STSC_IDLE: begin
                    // no format check: the move never depends on medium state
                    if (op_wr && is_seek) begin
                        fsm_reg <= stsc_pkg::STSC_SEEK_WAIT;
                        pos_start_reg <= 1'b1;
                        target_reg <= map_target;
                    end else if (op_wr && is_sense && feat_ok) begin
                        // standby does not gate the sense path
                        fsm_reg <= stsc_pkg::STSC_SENSE_WAIT;
                        temp_req_reg <= 1'b1;
                    end else if (op_wr) begin
                        fsm_reg <= stsc_pkg::STSC_FINISH;
                    end
                end
                stsc_pkg::STSC_SEEK_WAIT: begin
                    if (seek_fin || timeout) begin
                        fsm_reg <= stsc_pkg::STSC_FINISH;
                    end
                end
                stsc_pkg::STSC_SENSE_WAIT: begin
                    if (code_valid) begin
                        temp_req_reg <= 1'b0;
                        fsm_reg <= stsc_pkg::STSC_FINISH;
                    end
                end
                stsc_pkg::STSC_FINISH: begin
                    fsm_reg <= stsc_pkg::STSC_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // task-file registers: host writes while idle, results on completion
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            feature_reg <= 8'h00;
            count_reg <= 8'h00;
            low_reg <= 8'h00;
            mid_reg <= 8'h00;
            high_reg <= 8'h00;
            unit_reg <= 8'h00;
            opcode_reg <= 8'h00;
            standby_reg <= 1'b0;
        end else begin
            if (wr_en && paddr == `STSC_OFF_FEATURE) feature_reg <= wbyte;
            if (wr_en && paddr == `STSC_OFF_COUNT) count_reg <= wbyte;
            if (wr_en && paddr == `STSC_OFF_UNIT) unit_reg <= wbyte;
            if (wr_en && paddr == `STSC_OFF_CONTROL) standby_reg <= wbyte[0];
            if (op_wr) opcode_reg <= wbyte;
            if (fsm_reg == stsc_pkg::STSC_SENSE_WAIT && code_valid) begin
                count_reg <= code;
            end
            // block-address result overwrites the address bytes
            if (seek_fin && !pos_result.fail && target_reg.lba_mode) begin
                low_reg <= pos_result.address[7:0];
                mid_reg <= pos_result.address[15:8];
                high_reg <= pos_result.address[23:16];
                unit_reg[3:0] <= pos_result.address[27:24];
            end else begin
                if (wr_en && paddr == `STSC_OFF_ADDR_LOW) low_reg <= wbyte;
                if (wr_en && paddr == `STSC_OFF_ADDR_MID) mid_reg <= wbyte;
                if (wr_en && paddr == `STSC_OFF_ADDR_HIGH) high_reg <= wbyte;
            end
        end
    end

    // ============================================================
    // error and status bytes
    wire logic seek_bad;
    wire logic sense_bad;
    assign seek_bad = (seek_fin && pos_result.fail) || timeout;
    assign sense_bad = fsm_reg == stsc_pkg::STSC_IDLE && op_wr && !is_seek
        && !(is_sense && feat_ok);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            failure_reg <= 8'h00;
            state_reg <= `STSC_STATE_RESET;
        end else if (fsm_reg == stsc_pkg::STSC_IDLE && op_wr) begin
            // a new command clears old error and raises busy
            failure_reg <= sense_bad ? 8'h04 : 8'h00;
            state_reg <= 8'h80;
        end else if (seek_bad) begin
            // timeout means no target answered, otherwise abort
            failure_reg[`STSC_ERR_NOTFOUND_BIT] <= timeout;
            failure_reg[`STSC_ERR_ABORT_BIT] <= !timeout;
            state_reg[`STSC_ST_ERR_BIT] <= 1'b1;
        end else if (fsm_reg == stsc_pkg::STSC_FINISH) begin
            state_reg[`STSC_ST_BUSY_BIT] <= 1'b0;
            state_reg[`STSC_ST_RDY_BIT] <= 1'b1;
            state_reg[`STSC_ST_SEEKDONE_BIT] <= 1'b1;
            state_reg[`STSC_ST_ERR_BIT] <= failure_reg != 8'h00;
        end
    end

    // ============================================================
    // outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pos_start = pos_start_reg;
    assign pos_target = target_reg;
    assign temp_request = temp_req_reg;
    assign standby_hold = standby_reg;

    // ============================================================
    // checks
    a_seek_decode: assert property (@(posedge clk) disable iff (reset)
        fsm_reg == stsc_pkg::STSC_IDLE && op_wr && is_seek |=> pos_start)
        else $error("seek opcode did not start a move");
    a_seek_target: assert property (@(posedge clk) disable iff (reset)
        pos_start |-> pos_target.address[27:24] == unit_reg[3:0]
        && pos_target.address[7:0] == low_reg)
        else $error("target bytes wrong");
    a_sense_decode: assert property (@(posedge clk) disable iff (reset)
        fsm_reg == stsc_pkg::STSC_IDLE && op_wr && wbyte == 8'hF0
        && feature_reg == 8'h01 |=> temp_request)
        else $error("sense not started");
    a_feat_abort: assert property (@(posedge clk) disable iff (reset)
        fsm_reg == stsc_pkg::STSC_IDLE && op_wr && wbyte == 8'hF0
        && feature_reg != 8'h01 |=> failure_reg[2] ##2 state_reg[0])
        else $error("bad feature not aborted");
    a_code_low: assert property (@(posedge clk) disable iff (reset)
        temp_valid && fsm_reg == stsc_pkg::STSC_SENSE_WAIT
        && temp_half_deg <= -12'sd40 |=> code == 8'h00)
        else $error("cold code wrong");
    a_code_high: assert property (@(posedge clk) disable iff (reset)
        temp_valid && fsm_reg == stsc_pkg::STSC_SENSE_WAIT
        && temp_half_deg > 12'sd214 |=> code == 8'hFF)
        else $error("hot code wrong");
    a_result_store: assert property (@(posedge clk) disable iff (reset)
        fsm_reg == stsc_pkg::STSC_SENSE_WAIT && code_valid
        |=> count_reg == $past(code))
        else $error("count not loaded");
    a_lba_return: assert property (@(posedge clk) disable iff (reset)
        seek_fin && !pos_result.fail && target_reg.lba_mode
        |=> {high_reg, mid_reg, low_reg} == $past(pos_result.address[23:0]))
        else $error("address not returned");
    a_done_ready: assert property (@(posedge clk) disable iff (reset)
        fsm_reg == stsc_pkg::STSC_FINISH |=> !state_reg[7] && state_reg[6])
        else $error("busy not released");
    a_seek_fail: assert property (@(posedge clk) disable iff (reset)
        seek_bad |=> state_reg[0] && (failure_reg[4] || failure_reg[2]))
        else $error("failed move not flagged");
    c_seek_lba: cover property (@(posedge clk) disable iff (reset)
        seek_fin && target_reg.lba_mode);
    c_sense_ok: cover property (@(posedge clk) disable iff (reset)
        fsm_reg == stsc_pkg::STSC_SENSE_WAIT && code_valid);
    c_sense_standby: cover property (@(posedge clk) disable iff (reset)
        standby_reg && temp_request);
    c_seek_timeout: cover property (@(posedge clk) disable iff (reset)
        timeout);
endmodule // stsc_cmd
`default_nettype wire

// File: rtl/stsc_pkg.sv
// types for the positioning and temperature sense command block
package stsc_pkg;
    // target handed to the positioner
    typedef struct packed {
        logic lba_mode;
        logic [27:0] address;
    } stsc_target_s;
    // answer from the positioner
    typedef struct packed {
        logic done;
        logic fail;
        logic [27:0] address;
    } stsc_pos_result_s;
    typedef enum logic [2:0] {
        STSC_IDLE,
        STSC_SEEK_WAIT,
        STSC_SENSE_WAIT,
        STSC_FINISH
    } stsc_state_e;
endpackage

// File: rtl/stsc_temp_enc.sv
// encodes a signed half-degree temperature sample into the result code
`timescale 1ns/1ns
`default_nettype none
`include "stsc_cfg.svh"
module stsc_temp_enc (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // sample in: signed, units of half a degree
    input wire logic sample_valid,
    input wire logic signed [11:0] sample_half_deg,
    // code out
    output logic code_valid,
    output logic [7:0] code
);
    // offset by -20 deg (40 half-degrees) gives the code directly
    wire logic signed [12:0] shifted;
    wire logic [7:0] code_next;
    assign shifted = 13'(sample_half_deg) + 13'sd40;
    assign code_next = (shifted <= 13'sd0) ? `STSC_TEMP_MIN_CODE :
        (shifted > 13'sd254) ? `STSC_TEMP_MAX_CODE :
        shifted[7:0];
    // registered so the result is stable for the controller
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            code_valid <= 1'b0;
            code <= 8'h00;
        end else begin
            code_valid <= sample_valid;
            code <= sample_valid ? code_next : code;
        end
    end
endmodule // stsc_temp_enc
`default_nettype wire

// File: verification/stsc_partner.sv
// positioner and temperature sensor model facing the command block
`timescale 1ns/1ns
`default_nettype none
module stsc_partner (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // behaviour chosen by the bench
    input wire logic [3:0] lag,
    input wire logic fail_move,
    input wire logic mute_move,
    input wire logic signed [11:0] temp_now,
    // positioner side
    input wire logic pos_start,
    input wire stsc_pkg::stsc_target_s pos_target,
    output var stsc_pkg::stsc_pos_result_s pos_result,
    // sensor side
    input wire logic temp_request,
    output logic temp_valid,
    output logic signed [11:0] temp_half_deg
);
    logic mv_busy;
    logic [3:0] mv_cnt;
    logic tp_done;
    logic [3:0] tp_cnt;

    // ============================================================
    // movement and sampling, each after lag cycles
    // idle lines toggle so a stale value is never mistaken for data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_result <= '0;
            mv_busy <= 1'b0;
            mv_cnt <= 4'h0;
            tp_done <= 1'b0;
            tp_cnt <= 4'h0;
            temp_valid <= 1'b0;
            temp_half_deg <= 12'sh000;
        end else begin
            pos_result <= {1'b0, ~pos_result.fail, ~pos_result.address};
            temp_valid <= 1'b0;
            temp_half_deg <= ~temp_half_deg;
            if (pos_start) begin
                mv_busy <= !mute_move; // mute: head never settles
                mv_cnt <= lag;
            end else if (mv_busy && mv_cnt == 4'h0) begin
                mv_busy <= 1'b0;
                // lands one block past the target, the current address
                pos_result <= {1'b1, fail_move, pos_target.address + 28'h1};
            end else if (mv_busy) begin
                mv_cnt <= mv_cnt - 4'h1;
            end
            if (!temp_request) begin
                tp_done <= 1'b0;
                tp_cnt <= lag;
            end else if (!tp_done && tp_cnt == 4'h0) begin
                tp_done <= 1'b1;
                temp_valid <= 1'b1;
                temp_half_deg <= temp_now;
            end else if (!tp_done) begin
                tp_cnt <= tp_cnt - 4'h1;
            end
        end
    end
endmodule // stsc_partner
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the positioning and temperature sense block
`timescale 1ns/1ns
`default_nettype none
`include "stsc_cfg.svh"
module testbench;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pos_start, temp_request, temp_valid, standby_hold;
    stsc_pkg::stsc_target_s pos_target;
    stsc_pkg::stsc_pos_result_s pos_result;
    logic signed [11:0] temp_half_deg, temp_now;
    logic [3:0] lag;
    logic fail_move, mute_move;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 92;
    int starts = 0;
    int tc[8] = '{-41, -40, -39, 0, 213, 214, 215, 2047};

    // ============================================================
    // design and far side; short timeout keeps the run brief
    stsc_cmd #(.SEEK_TIMEOUT(20)) stsc_cmd_inst (.clk(clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pos_start(pos_start), .pos_target(pos_target),
        .pos_result(pos_result), .temp_request(temp_request),
        .temp_valid(temp_valid), .temp_half_deg(temp_half_deg),
        .standby_hold(standby_hold));
    stsc_partner stsc_partner_inst (.clk(clk), .reset(reset), .lag(lag),
        .fail_move(fail_move), .mute_move(mute_move), .temp_now(temp_now),
        .pos_start(pos_start), .pos_target(pos_target),
        .pos_result(pos_result), .temp_request(temp_request),
        .temp_valid(temp_valid), .temp_half_deg(temp_half_deg));

    // ============================================================
    // clock and start pulse count
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (pos_start === 1'b1) starts <= starts + 1;

    // ============================================================
    // helpers
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer; idle cycle first so psel is never assigned twice
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // hold the request until pready is sampled high at a rising edge
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        if (n >= 40) begin
            mismatches++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, `STSC_OFF_STATE, 8'h00);
            n++;
        end while (q[7] !== 1'b0 && n < 60);
        if (q[7] !== 1'b0) begin
            mismatches++;
            print_verdict();
        end
    endtask
    task automatic outcome(input logic [7:0] fexp);
        apb(1'b0, `STSC_OFF_FAILURE, 8'h00);
        chk(q, {24'h0, fexp});
        apb(1'b0, `STSC_OFF_STATE, 8'h00);
        chk(q & 32'hC1, {24'h0, 7'h20, fexp != 8'h00});
    endtask
    function automatic logic [7:0] enc(input int h);
        if (h <= -40) return 8'h00;
        if (h > 214) return 8'hFF;
        return 8'(h + 40);
    endfunction

    // ============================================================
    // seek: load bytes, issue, check target, status and read-back
    task automatic seek(input logic [7:0] op, input logic lba,
                        input logic [27:0] a, input logic fl, input logic mt);
        int s0;
        logic [27:0] x;
        s0 = starts;
        lag <= {1'b0, 3'($random(seed))};
        fail_move <= fl;
        mute_move <= mt;
        apb(1'b1, `STSC_OFF_UNIT, {1'b1, lba, 2'b10, a[27:24]});
        apb(1'b1, `STSC_OFF_ADDR_LOW, a[7:0]);
        apb(1'b1, `STSC_OFF_ADDR_MID, a[15:8]);
        apb(1'b1, `STSC_OFF_ADDR_HIGH, a[23:16]);
        apb(1'b1, `STSC_OFF_OPCODE, op);
        wait_idle();
        chk(32'(starts - s0), 32'h1);
        chk({3'h0, pos_target}, {3'h0, lba, a});
        outcome(fl ? 8'h04 : (mt ? 8'h10 : 8'h00));
        x = (lba && !fl && !mt) ? a + 28'h1 : a;
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 12'(`STSC_OFF_ADDR_LOW + 4 * k), 8'h00);
            chk(q & (k == 3 ? 32'h0F : 32'hFF), {24'h0, 8'(x >> (8 * k))} & (k == 3 ? 32'h0F : 32'hFF));
        end
    endtask

    // temperature sense with a chosen feature value and sample
    task automatic sense(input logic [7:0] ft, input int h, input logic sb);
        lag <= {1'b0, 3'($random(seed))};
        temp_now <= 12'(h);
        apb(1'b1, `STSC_OFF_CONTROL, {7'h0, sb});
        apb(1'b1, `STSC_OFF_FEATURE, ft);
        chk({31'h0, standby_hold}, {31'h0, sb});
        apb(1'b1, `STSC_OFF_OPCODE, 8'hF0);
        wait_idle();
        outcome(ft == 8'h01 ? 8'h00 : 8'h04);
        apb(1'b0, `STSC_OFF_COUNT, 8'h00);
        if (ft == 8'h01) chk(q, {24'h0, enc(h)});
    endtask

    // ============================================================
    // main sequence
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lag = 4'h0;
        fail_move = 1'b0;
        mute_move = 1'b0;
        temp_now = 12'sh000;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, `STSC_OFF_STATE, 8'h00);
        chk(q, 32'h50);
        apb(1'b0, 12'h028, 8'h00);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        for (int i = 0; i < 16; i++) seek(8'h70 + 8'(i), i[0], 28'($random(seed)), 1'b0, 1'b0);
        seek(8'h7F, 1'b1, 28'hFFFFFFF, 1'b0, 1'b0);
        seek(8'h75, 1'b1, 28'h1234567, 1'b1, 1'b0);
        seek(8'h70, 1'b0, 28'h7654321, 1'b0, 1'b1);
        foreach (tc[i]) sense(8'h01, tc[i], i[0]);
        repeat (6) sense(8'h01, $random(seed) % 300, 1'b1);
        sense(8'h00, 0, 1'b0);
        sense(8'h81, 0, 1'b1);
        sense(8'hFF, 0, 1'b0);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
